/* File: common/rio_pkg.sv */
// Shared constants, map and helper arithmetic for the remote I/O master and its stations.
// Assumes a single 25 MHz clock (mclk) with a synchronous active-high reset (srst).
//
// Functional notes
// - Master runs only with station number zero
// - Stations one to seven are slaves only
// - Link speed is 19200 or 38400 baud
// - Table start address is programmable, default V37700
// - Table is four-word blocks, first block reserved
// - Block: input addr, input count, output addr, output count
// - Software fills all 32 words, zeros if absent
// - Table is read once after reset
// - Any non-zero block word means slave present
// - Polling starts only once completion relay is set
// - At most 512 remote points per channel
// - At most seven remote stations served
// - One shared pair: drive only while others silent
// - Station addresses unique; only master uses zero
// - Remote points live apart from local points
// - Stations use the same baud as master
// - Software writes the table once at startup
package rio_pkg;

  localparam int CLK_HZ = 25_000_000;
  localparam int BAUD_LOW = 19200;
  localparam int BAUD_HIGH = 38400;
  localparam logic [11:0] DIV_LOW = 12'(CLK_HZ / BAUD_LOW);
  localparam logic [11:0] DIV_HIGH = 12'(CLK_HZ / BAUD_HIGH);

  localparam logic [2:0] MASTER_STATION = 3'h0;
  localparam logic [2:0] FIRST_STATION = 3'h1;
  localparam logic [2:0] LAST_STATION = 3'h7;
  localparam logic [4:0] LAST_TABLE_WORD = 5'h1F;
  localparam logic [17:0] MAX_POINTS = 18'h0_0200;
  localparam logic [7:0] REPLY_TAG = 8'h80;

  // Link timing in bit times
  localparam logic [5:0] FRAME_GAP_BITS = 6'h06;
  localparam logic [5:0] HUNT_BITS = 6'h04;
  localparam logic [5:0] TURN_BITS = 6'h02;
  localparam logic [5:0] REPLY_WAIT_BITS = 6'h3C;
  localparam logic [3:0] STOP_BIT = 4'h9;

  // Register map (byte offsets) and fields
  localparam logic [11:0] CTRL_OFS = 12'h000;
  localparam logic [11:0] BASE_OFS = 12'h004;
  localparam logic [11:0] STAT_OFS = 12'h008;
  localparam logic [3:0] MEM_PAGE = 4'h1;
  localparam int RELAY_BIT = 0;
  localparam int BAUD_BIT = 1;
  localparam int STATION_LSB = 2;
  localparam int STAT_LOADED_BIT = 0;
  localparam int STAT_OVER_BIT = 1;
  localparam int STAT_MASK_LSB = 8;
  localparam int STAT_ERR_LSB = 16;
  localparam logic BAUD_RESET = 1'b1;
  localparam logic [15:0] BASE_RESET = 16'h3FC0;

  function automatic logic [11:0] baud_divisor(input logic high);
    return high ? DIV_HIGH : DIV_LOW;
  endfunction

  function automatic logic [17:0] bit_cycles(input logic [11:0] div, input logic [5:0] n);
    return 18'(div) * 18'(n);
  endfunction

endpackage

/* File: common/rio_link_if.sv */
// Half-duplex remote I/O link between the master and one station.
// The shared pair idles high when nobody drives it.
`timescale 1ns/1ns
interface rio_link_if;
  logic m_out;
  logic m_oe;
  logic s_out;
  logic s_oe;
  logic line;

  assign line = m_oe ? m_out : (s_oe ? s_out : 1'b1);

  modport master (output m_out, output m_oe, input line);
  modport station (output s_out, output s_oe, input line);
endinterface

/* File: src/octet_serial.sv */
// Byte serialiser for the half-duplex link: 8 data bits, no parity, one stop bit.
// The receiver is deaf while this end transmits, so its own echo is never taken.
`timescale 1ns/1ns
module octet_serial
  import rio_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [11:0] divisor,
  input wire logic tx_start,
  input wire logic [7:0] tx_byte,
  output logic tx_busy,
  output logic tx_out,
  output logic tx_oe,
  input wire logic rx_line,
  output logic rx_busy,
  output logic rx_valid,
  output logic [7:0] rx_byte
);

  logic rx_s1, rx_s2, rx_s3;
  logic [11:0] tx_cnt, next_tx_cnt, rx_cnt, next_rx_cnt;
  logic [3:0] tx_bit, next_tx_bit, rx_bit, next_rx_bit;
  logic [9:0] tx_sh, next_tx_sh;
  logic next_tx_busy, next_rx_busy, next_rx_valid;
  logic [7:0] next_rx_byte;

  assign tx_out = tx_sh[0];
  assign tx_oe = tx_busy;

  always_comb begin
    next_tx_busy = tx_busy;
    next_tx_cnt = tx_cnt;
    next_tx_bit = tx_bit;
    next_tx_sh = tx_sh;
    next_rx_busy = rx_busy;
    next_rx_cnt = rx_cnt;
    next_rx_bit = rx_bit;
    next_rx_byte = rx_byte;
    next_rx_valid = 1'b0;
    if (!tx_busy) begin
      if (tx_start) begin
        next_tx_busy = 1'b1;
        next_tx_sh = {1'b1, tx_byte, 1'b0};
        next_tx_cnt = 12'h000;
        next_tx_bit = 4'h0;
      end
    end else if (tx_cnt == 12'(divisor - 12'h001)) begin
      next_tx_cnt = 12'h000;
      next_tx_sh = {1'b1, tx_sh[9:1]};
      next_tx_bit = 4'(tx_bit + 4'h1);
      if (tx_bit == STOP_BIT) begin
        next_tx_busy = 1'b0;
      end
    end else begin
      next_tx_cnt = 12'(tx_cnt + 12'h001);
    end
    // Start edge seen on the synchronised line; sample each bit mid-cell
    if (!rx_busy) begin
      if (!tx_busy && rx_s3 && !rx_s2) begin
        next_rx_busy = 1'b1;
        next_rx_cnt = {1'b0, divisor[11:1]};
        next_rx_bit = 4'h0;
      end
    end else if (rx_cnt != 12'h000) begin
      next_rx_cnt = 12'(rx_cnt - 12'h001);
    end else begin
      next_rx_cnt = 12'(divisor - 12'h001);
      next_rx_bit = 4'(rx_bit + 4'h1);
      if (rx_bit == 4'h0 && rx_s2) begin
        next_rx_busy = 1'b0;
      end else if (rx_bit == STOP_BIT) begin
        next_rx_busy = 1'b0;
        next_rx_valid = rx_s2;
      end else if (rx_bit != 4'h0) begin
        next_rx_byte = {rx_s2, rx_byte[7:1]};
      end
    end
  end

  always_ff @(posedge mclk) begin
    rx_s1 <= rx_line;
    rx_s2 <= rx_s1;
    rx_s3 <= rx_s2;
    if (srst) begin
      tx_busy <= 1'b0;
      tx_cnt <= 12'h000;
      tx_bit <= 4'h0;
      tx_sh <= 10'h3FF;
      rx_busy <= 1'b0;
      rx_cnt <= 12'h000;
      rx_bit <= 4'h0;
      rx_byte <= 8'h00;
      rx_valid <= 1'b0;
    end else begin
      tx_busy <= next_tx_busy;
      tx_cnt <= next_tx_cnt;
      tx_bit <= next_tx_bit;
      tx_sh <= next_tx_sh;
      rx_busy <= next_rx_busy;
      rx_cnt <= next_rx_cnt;
      rx_bit <= next_rx_bit;
      rx_byte <= next_rx_byte;
      rx_valid <= next_rx_valid;
    end
  end

endmodule

/* File: src/remote_station.sv */
// Remote slave station end: answers master frames addressed to its own station number.
// Station number and baud strap must be static while the link runs.
`timescale 1ns/1ns
module remote_station
  import rio_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic [2:0] station,
  input wire logic baud_high,
  input wire logic [7:0] field_in,
  output logic [7:0] field_out,
  rio_link_if.station link
);

  typedef enum logic [5:0] {
    S_HUNT = 6'h01,
    S_ADDR = 6'h02,
    S_DATA = 6'h04,
    S_TURN = 6'h08,
    S_TAG = 6'h10,
    S_VAL = 6'h20
  } sstate_type;

  sstate_type state, next_state;
  logic [17:0] idle_cnt, next_idle_cnt;
  logic [7:0] in_s1, in_s2, next_field_out;
  logic [11:0] divisor;
  logic tx_start, tx_busy, rx_busy, rx_valid;
  logic [7:0] tx_byte, rx_byte;

  assign divisor = baud_divisor(baud_high);

  octet_serial serial (
    .mclk(mclk),
    .srst(srst),
    .divisor(divisor),
    .tx_start(tx_start),
    .tx_byte(tx_byte),
    .tx_busy(tx_busy),
    .tx_out(link.s_out),
    .tx_oe(link.s_oe),
    .rx_line(link.line),
    .rx_busy(rx_busy),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );

  always_comb begin
    next_state = state;
    next_field_out = field_out;
    tx_start = 1'b0;
    tx_byte = 8'h00;
    next_idle_cnt = (rx_busy || tx_busy) ? 18'h0_0000 : 18'(idle_cnt + 18'h0_0001);
    case (state)
      // Byte framing is regained from line silence
      S_HUNT: if (idle_cnt >= bit_cycles(divisor, HUNT_BITS)) next_state = S_ADDR;
      S_ADDR: begin
        if (rx_valid) begin
          if (rx_byte == {5'h00, station} && station != MASTER_STATION) begin
            next_state = S_DATA;
          end else begin
            next_state = S_HUNT;
          end
        end
      end
      S_DATA: begin
        if (rx_valid) begin
          next_field_out = rx_byte;
          next_state = S_TURN;
        end else if (idle_cnt >= bit_cycles(divisor, HUNT_BITS)) begin
          next_state = S_ADDR;
        end
      end
      // Let the master's stop bit finish before taking the pair
      S_TURN: begin
        if (idle_cnt >= bit_cycles(divisor, TURN_BITS)) begin
          tx_start = 1'b1;
          tx_byte = REPLY_TAG | {5'h00, station};
          next_state = S_TAG;
        end
      end
      S_TAG: begin
        if (!tx_busy) begin
          tx_start = 1'b1;
          tx_byte = in_s2;
          next_state = S_VAL;
        end
      end
      S_VAL: if (!tx_busy) next_state = S_HUNT;
      default: next_state = S_HUNT;
    endcase
  end

  always_ff @(posedge mclk) begin
    in_s1 <= field_in;
    in_s2 <= in_s1;
    if (srst) begin
      state <= S_HUNT;
      idle_cnt <= 18'h0_0000;
      field_out <= 8'h00;
    end else begin
      state <= next_state;
      idle_cnt <= next_idle_cnt;
      field_out <= next_field_out;
    end
  end

endmodule

/* File: src/remote_io_master.sv */
// Remote I/O master end: loads the slave table from its user memory, then polls stations.
// Software reaches control, status and the user memory window over APB (12-bit address).
//
// Our own choices: the APB slave port and the register addresses.
`timescale 1ns/1ns
module remote_io_master
  import rio_pkg::*;
(
  input wire logic mclk,
  input wire logic srst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  rio_link_if.master link
);

  typedef enum logic [6:0] {
    M_WAIT = 7'h01,
    M_LOAD = 7'h02,
    M_PICK = 7'h04,
    M_ADDR = 7'h08,
    M_DATA = 7'h10,
    M_REPLY = 7'h20,
    M_STORE = 7'h40
  } mstate_type;

  // User memory window; remote points map here, never onto local I/O
  logic [15:0] mem [64];
  logic [15:0] tbl [32];
  logic [15:0] next_tbl [32];

  mstate_type state, next_state;
  logic [4:0] idx, next_idx;
  logic [2:0] sta, next_sta;
  logic [17:0] timer, next_timer;
  logic loaded, next_loaded;
  logic [7:0] errs, next_errs;
  logic rx_first, next_rx_first;
  logic [7:0] rx_data, next_rx_data;

  logic relay, next_relay, baud_high, next_baud_high;
  logic [2:0] station, next_station_num;
  logic [15:0] base, next_base;
  logic [31:0] next_prdata;
  logic next_pready, next_pslverr;

  logic [7:0] present, enabled;
  logic overflow;
  logic [17:0] points, trial;
  logic acc, hold, mem_hit, mem_we;
  logic [5:0] mem_wa;
  logic [15:0] mem_wd;
  logic [11:0] divisor;
  logic tx_start, tx_busy, rx_valid;
  logic [7:0] tx_byte, rx_byte;

  function automatic logic [2:0] station_after(input logic [2:0] s);
    return (s == LAST_STATION) ? FIRST_STATION : 3'(s + 3'h1);
  endfunction

  function automatic logic [7:0] point_mask(input logic [15:0] count);
    return (count >= 16'h0008) ? 8'hFF : 8'((9'h001 << count[3:0]) - 9'h001);
  endfunction

  assign divisor = baud_divisor(baud_high);

  octet_serial serial (
    .mclk(mclk),
    .srst(srst),
    .divisor(divisor),
    .tx_start(tx_start),
    .tx_byte(tx_byte),
    .tx_busy(tx_busy),
    .tx_out(link.m_out),
    .tx_oe(link.m_oe),
    .rx_line(link.line),
    .rx_busy(),
    .rx_valid(rx_valid),
    .rx_byte(rx_byte)
  );

  // ==========================================================
  // Slave presence and point budget
  always_comb begin
    points = 18'h0_0000;
    trial = 18'h0_0000;
    present = 8'h00;
    enabled = 8'h00;
    overflow = 1'b0;
    for (int k = 1; k < 8; k++) begin
      // Block k holds input addr, input count, output addr, output count
      present[k] = |{tbl[4*k], tbl[4*k+1], tbl[4*k+2], tbl[4*k+3]};
      if (present[k]) begin
        trial = 18'(points + 18'(tbl[4*k+1]) + 18'(tbl[4*k+3]));
        // Stations past the point budget stay silent rather than truncated
        if (trial <= MAX_POINTS) begin
          enabled[k] = 1'b1;
          points = trial;
        end else begin
          overflow = 1'b1;
        end
      end
    end
  end

  // ==========================================================
  // Load and poll sequencer
  always_comb begin
    next_state = state;
    next_idx = idx;
    next_sta = sta;
    next_timer = timer;
    next_tbl = tbl;
    next_loaded = loaded;
    next_errs = errs;
    next_rx_first = rx_first;
    next_rx_data = rx_data;
    tx_start = 1'b0;
    tx_byte = 8'h00;
    case (state)
      M_WAIT: if (relay && station == MASTER_STATION) next_state = M_LOAD;
      M_LOAD: begin
        next_tbl[idx] = mem[6'(base[5:0] + {1'b0, idx})];
        next_idx = 5'(idx + 5'h01);
        if (idx == LAST_TABLE_WORD) begin
          next_loaded = 1'b1;
          next_state = M_PICK;
        end
      end
      M_PICK: begin
        next_timer = 18'h0_0000;
        if (station != MASTER_STATION) begin
          next_state = M_PICK;
        end else if (enabled[sta]) begin
          next_state = M_ADDR;
        end else begin
          next_sta = station_after(sta);
        end
      end
      // Silence before each frame lets stations regain byte framing
      M_ADDR: begin
        if (timer >= bit_cycles(divisor, FRAME_GAP_BITS)) begin
          tx_start = 1'b1;
          tx_byte = {5'h00, sta};
          next_state = M_DATA;
        end else begin
          next_timer = 18'(timer + 18'h0_0001);
        end
      end
      M_DATA: begin
        if (!tx_busy) begin
          tx_start = 1'b1;
          tx_byte = mem[tbl[{sta, 2'b10}][5:0]][7:0] & point_mask(tbl[{sta, 2'b11}]);
          next_timer = 18'h0_0000;
          next_rx_first = 1'b1;
          next_state = M_REPLY;
        end
      end
      M_REPLY: begin
        next_timer = 18'(timer + 18'h0_0001);
        if (rx_valid && rx_first) begin
          if (rx_byte == (REPLY_TAG | {5'h00, sta})) begin
            next_rx_first = 1'b0;
          end else begin
            next_errs = (errs == 8'hFF) ? errs : 8'(errs + 8'h01);
            next_sta = station_after(sta);
            next_state = M_PICK;
          end
        end else if (rx_valid) begin
          next_rx_data = rx_byte;
          next_state = M_STORE;
        end else if (timer >= bit_cycles(divisor, REPLY_WAIT_BITS)) begin
          next_errs = (errs == 8'hFF) ? errs : 8'(errs + 8'h01);
          next_sta = station_after(sta);
          next_state = M_PICK;
        end
      end
      M_STORE: begin
        next_sta = station_after(sta);
        next_state = M_PICK;
      end
      default: next_state = M_WAIT;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      state <= M_WAIT;
      idx <= 5'h00;
      sta <= FIRST_STATION;
      timer <= 18'h0_0000;
      loaded <= 1'b0;
      errs <= 8'h00;
      rx_first <= 1'b1;
      rx_data <= 8'h00;
      for (int i = 0; i < 32; i++) begin
        tbl[i] <= 16'h0000;
      end
    end else begin
      state <= next_state;
      idx <= next_idx;
      sta <= next_sta;
      timer <= next_timer;
      loaded <= next_loaded;
      errs <= next_errs;
      rx_first <= next_rx_first;
      rx_data <= next_rx_data;
      tbl <= next_tbl;
    end
  end

  // ==========================================================
  // APB register slave; one wait state, stretched while a reply is stored
  assign acc = psel && penable && !pready;
  assign hold = (state == M_STORE);
  assign mem_hit = (paddr[11:8] == MEM_PAGE);

  always_comb begin
    next_relay = relay;
    next_baud_high = baud_high;
    next_station_num = station;
    next_base = base;
    next_prdata = 32'h0000_0000;
    next_pslverr = 1'b0;
    next_pready = acc && !hold;
    if (acc && !hold) begin
      if (mem_hit) begin
        next_prdata = {16'h0000, mem[paddr[7:2]]};
      end else begin
        case (paddr)
          CTRL_OFS: begin
            next_prdata = {27'h000_0000, station, baud_high, relay};
            if (pwrite) begin
              next_relay = pwdata[RELAY_BIT];
              next_baud_high = pwdata[BAUD_BIT];
              next_station_num = pwdata[STATION_LSB +: 3];
            end
          end
          BASE_OFS: begin
            next_prdata = {16'h0000, base};
            if (pwrite) next_base = pwdata[15:0];
          end
          STAT_OFS: begin
            next_prdata[STAT_LOADED_BIT] = loaded;
            next_prdata[STAT_OVER_BIT] = overflow;
            next_prdata[STAT_MASK_LSB +: 8] = enabled;
            next_prdata[STAT_ERR_LSB +: 8] = errs;
          end
          default: next_pslverr = 1'b1;
        endcase
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (srst) begin
      relay <= 1'b0;
      baud_high <= BAUD_RESET;
      station <= MASTER_STATION;
      base <= BASE_RESET;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      relay <= next_relay;
      baud_high <= next_baud_high;
      station <= next_station_num;
      base <= next_base;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================
  // User memory writes: stored replies, else software
  always_comb begin
    mem_we = 1'b0;
    mem_wa = paddr[7:2];
    mem_wd = pwdata[15:0];
    if (state == M_STORE) begin
      mem_we = 1'b1;
      mem_wa = tbl[{sta, 2'b00}][5:0];
      mem_wd = {8'h00, rx_data & point_mask(tbl[{sta, 2'b01}])};
    end else if (acc && pwrite && mem_hit) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

endmodule

/* File: verification/rio_link_monitor.sv */
// Concurrent checks on the half-duplex link between the master and one station.
// Assumes both ends run at 38400 baud; the bench instantiates it beside the interface.
`timescale 1ns/1ns
module rio_link_monitor (
  input wire logic mclk,
  input wire logic srst,
  input wire logic m_out,
  input wire logic m_oe,
  input wire logic s_out,
  input wire logic s_oe,
  input wire logic line
);
  localparam int BIT = 651;
  int low_run;
  int idle_run;
  int m_on;
  int s_on;
  // Every transmission is a byte pair sent back to back; flags mark the second byte
  logic m_d;
  logic s_d;
  logic m_second;
  logic s_second;

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (srst);

  // ==========================================================================
  // Helper counters
  // Idle count starts saturated so the first frame after reset is not flagged
  always_ff @(posedge mclk) begin
    if (srst) begin
      low_run <= 0;
      idle_run <= 100000;
      m_on <= 0;
      s_on <= 0;
      m_d <= 1'b0;
      s_d <= 1'b0;
      m_second <= 1'b0;
      s_second <= 1'b0;
    end else begin
      low_run <= line ? 0 : low_run + 1;
      if (m_oe || s_oe) begin
        idle_run <= 0;
      end else if (idle_run < 100000) begin
        idle_run <= idle_run + 1;
      end
      m_on <= m_oe ? m_on + 1 : 0;
      s_on <= s_oe ? s_on + 1 : 0;
      m_d <= m_oe;
      s_d <= s_oe;
      if (m_oe && !m_d) begin
        m_second <= !m_second;
      end
      if (s_oe && !s_d) begin
        s_second <= !s_second;
      end
    end
  end

  // ==========================================================================
  // Link ownership and framing
  AST_ONE_DRIVER: assert property (!(m_oe && s_oe))
    else $error("both ends drive the link");
  AST_RESET_QUIET: assert property ($fell(srst) |-> !m_oe && !s_oe && m_out && s_out)
    else $error("link not released after reset");
  AST_LOW_BITS: assert property ($rose(line) && $past(m_oe || s_oe) |-> (low_run % BIT) == 0)
    else $error("low run not a whole number of bit times");
  AST_M_RELEASE: assert property ($fell(m_oe) |-> $past(m_out))
    else $error("master released the link while low");
  AST_S_RELEASE: assert property ($fell(s_oe) |-> $past(s_out))
    else $error("station released the link while low");
  // The second byte of a pair follows one idle cycle later, so only the first needs a gap
  AST_TURN_GAP: assert property ($rose(s_oe) && !s_second |-> idle_run >= BIT)
    else $error("station drove without a quiet turnaround");
  AST_FRAME_GAP: assert property ($rose(m_oe) && !m_second |-> idle_run >= 4 * BIT)
    else $error("master frame started without idle gap");
  AST_M_LEN: assert property (m_oe |-> m_on <= 21 * BIT)
    else $error("master held the link too long");
  AST_S_LEN: assert property (s_oe |-> s_on <= 21 * BIT)
    else $error("station held the link too long");
endmodule

/* File: verification/remote_io_master_config_tb.sv */
// Self-checking bench: master and station joined by one link interface.
// Assumes a 25 MHz clock, synchronous active-high reset and APB access to the master.
`timescale 1ns/1ns
module remote_io_master_config_tb;
  import rio_pkg::*;
  logic mclk = 1'b0;
  logic srst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] field_in = 8'h3C;
  logic [7:0] field_out;
  logic [31:0] rd;
  logic er;
  logic [15:0] tbl [32];
  int num_errors = 0;
  int n_tests = 0;
  int cyc = 0;

  rio_link_if link();
  remote_io_master i_remote_io_master (.mclk(mclk), .srst(srst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link.master));
  remote_station i_remote_station (.mclk(mclk), .srst(srst), .station(3'h1),
    .baud_high(1'b1), .field_in(field_in), .field_out(field_out), .link(link.station));
  rio_link_monitor i_rio_link_monitor (.mclk(mclk), .srst(srst), .m_out(link.m_out),
    .m_oe(link.m_oe), .s_out(link.s_out), .s_oe(link.s_oe), .line(link.line));

  always #20 mclk = ~mclk;

  // ==========================================================================
  // Shared tasks
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // Polling cut short by the bench's own ceiling
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 60000) begin
      num_errors++;
      wrap_up();
    end
  end

  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // One APB transfer; waits for pready however long the slave stretches it
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do begin
      @(posedge mclk);
    end while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rd_chk(input string name, input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(name, rd, exp);
  endtask

  // Longer than a table load plus a frame gap, so a wrongly started master is seen
  task automatic quiet(input string name);
    logic bad;
    bad = 1'b0;
    repeat (4200) begin
      @(posedge mclk);
      if (link.m_oe !== 1'b0) begin
        bad = 1'b1;
      end
    end
    check(name, {31'h0, bad}, 32'h0000_0000);
  endtask

  // ==========================================================================
  // Scenarios
  task automatic t_reset();
    rd_chk("ctrl_rst", CTRL_OFS, 32'h0000_0002);
    rd_chk("base_rst", BASE_OFS, 32'h0000_3FC0);
    apb(1'b1, STAT_OFS, 32'hFFFF_FFFF);
    rd_chk("stat_rst", STAT_OFS, 32'h0000_0000);
    apb(1'b0, 12'h00C, 32'h0000_0000);
    check("unmapped_err", {31'h0, er}, 32'h0000_0001);
    check("unmapped_data", rd, 32'h0000_0000);
    $display("test reset done");
  endtask

  // Table at word 8; reserved block non-zero, station 3 breaks the point budget
  task automatic t_table();
    foreach (tbl[i]) tbl[i] = 16'h0000;
    tbl[0] = 16'h1111;
    tbl[3] = 16'h2222;
    tbl[4] = 16'h0030;
    tbl[5] = 16'h0008;
    tbl[6] = 16'h0031;
    tbl[7] = 16'h0004;
    tbl[13] = 16'h01F8;
    tbl[22] = 16'h0032;
    apb(1'b1, BASE_OFS, 32'h0000_0008);
    rd_chk("base_wr", BASE_OFS, 32'h0000_0008);
    // The whole table, absent blocks as zeros, is written once before the relay
    for (int i = 0; i < 32; i++) begin
      apb(1'b1, 12'h100 + 12'(4 * (8 + i)), {16'h0000, tbl[i]});
    end
    apb(1'b1, 12'h1C0, 32'h0000_0000);
    apb(1'b1, 12'h1C4, 32'h0000_00A5);
    $display("test table done");
  endtask

  task automatic t_gate();
    quiet("idle_no_relay");
    apb(1'b1, CTRL_OFS, 32'h0000_000F);
    quiet("idle_station3");
    rd_chk("stat_station3", STAT_OFS, 32'h0000_0000);
    apb(1'b1, CTRL_OFS, 32'h0000_0003);
    repeat (40) @(posedge mclk);
    rd_chk("stat_loaded", STAT_OFS, 32'h0000_2203);
    // Later edits to the table must not be picked up
    apb(1'b1, 12'h100 + 12'(4 * 14), 32'h0000_0032);
    $display("test gate done");
  endtask

  task automatic t_poll();
    int n;
    for (n = 0; n < 40000 && field_out !== 8'h05; n++) begin
      @(posedge mclk);
    end
    check("field_out", {24'h0, field_out}, 32'h0000_0005);
    repeat (15500) @(posedge mclk);
    rd_chk("in_store", 12'h1C0, 32'h0000_003C);
    rd_chk("stat_run", STAT_OFS, 32'h0000_2203);
    $display("test poll done");
  endtask

  initial begin
    repeat (6) @(posedge mclk);
    srst <= 1'b0;
    @(posedge mclk);
    t_reset();
    t_table();
    t_gate();
    t_poll();
    wrap_up();
  end
endmodule
